// *** hdl/cis_pkg.sv ***
// constants and types for the cpu interrupt sequencer
package cis_pkg;
  // ============================================================
  // sizes
  localparam int NPER = 8;
  localparam int NPEND = 8;
  localparam logic [2:0] NBYTE = 3'h4;
  // ============================================================
  // register byte addresses
  localparam logic [7:0] A_LEVEL = 8'h00;
  localparam logic [7:0] A_LCA = 8'h04;
  localparam logic [7:0] A_LCB = 8'h08;
  localparam logic [7:0] A_FVEC = 8'h0C;
  localparam logic [7:0] A_VBASE = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_FLAG = 8'h18;
  // level control bits
  localparam int B_FSEL = 0;
  localparam int B_DMA7 = 1;
  // ============================================================
  // flag register layout
  localparam int FB_O = 2;
  localparam int FB_I = 6;
  localparam int FB_U = 7;
  localparam int FB_IPL = 12;
  localparam logic [31:0] FLG_RST = 32'h0000_0000;
  localparam logic [31:0] VBASE_RST = 32'h0000_0000;
  localparam logic [2:0] LVL_FAST = 3'h7;
  // ============================================================
  // pending slots, fixed priority: lowest index first
  localparam int P_UND = 0;
  localparam int P_OVF = 1;
  localparam int P_BRK = 2;
  localparam int P_DBG = 3;
  localparam int P_INT = 4;
  localparam int P_NMI = 5;
  localparam int P_SYS = 6;
  localparam int P_STEP = 7;
  localparam logic [31:0] FIX_VEC [NPEND] = '{
    32'h0FFF_FFDC, 32'h0FFF_FFE0, 32'h0FFF_FFE4, 32'h0FFF_FFE8,
    32'h0000_0000, 32'h0FFF_FFF8, 32'h0FFF_FFF0, 32'h0FFF_FFEC};
  localparam logic [7:0] INT_HI = 8'h80;
  localparam logic [7:0] PER_NUM0 = 8'h08;
  localparam logic [7:0] BYTE_FF = 8'hFF;
  // ============================================================
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_FETCH = 3'b010,
    S_JUMP = 3'b100
  } cis_state_t;
endpackage

// *** hdl/cis_sequencer.sv ***
// interrupt acceptance, vector fetch and fast path for the cpu core
//
// Behaviour
// [RQ1] maskable requests gated by the I flag, ranked by programmed level
// [RQ2] non-maskable sources bypass the I flag, fixed priority
// [RQ3] software traps are non-maskable, raised by executing the trap opcode
// [RQ4] undefined opcode trap raises the undefined instruction interrupt
// [RQ5] overflow trap raises only when the O flag is 1
// [RQ6] arithmetic results update the O flag
// [RQ7] break opcode raises the break interrupt each time
// [RQ8] debug break has its own vector; debug break and single step reserved
// [RQ9] numbered trap 0..255; 0..127 share peripheral handlers
// [RQ10] trap 0..127 saves U, selects interrupt stack, return restores U
// [RQ11] trap 128..255 keeps the active stack pointer
// [RQ12] only one peripheral, level 7, may use the fast path
// [RQ13] pin interrupt raised on a high to low transition
// [RQ14] five special interrupts: pin, watchdog, osc stop, low voltage, step
// [RQ15] peripheral requests maskable, use the slot of trap number alike
// [RQ16] software sets fast select, clears level7 dma, loads fast vector
// [RQ17] software gives the fast source level 7 and no other source
// [RQ18] fast accept copies flags and pc to shadows, jumps to fast vector
// [RQ19] fast return restores flags and pc from the shadows
// [RQ20] vectors are 4 bytes; accepted request jumps to that address
// [RQ21] fixed vectors live in FFFFFDCh..FFFFFFFh
// [RQ22] relocatable table is 1024 bytes from the vector base
// [RQ23] requests accepted only at instruction boundaries
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module cis_sequencer
  import cis_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // core execution
  input wire logic insn_boundary,
  input wire logic [31:0] cur_pc,
  input wire logic ex_undef,
  input wire logic ex_ovf_trap,
  input wire logic ex_break,
  input wire logic ex_dbg_break,
  input wire logic ex_int,
  input wire logic [7:0] ex_int_num,
  input wire logic ex_fast_ret,
  input wire logic ex_ret,
  input wire logic [31:0] ret_flag,
  input wire logic alu_ovf_we,
  input wire logic alu_ovf,
  // sources
  input wire logic nmi_pin_n,
  input wire logic wdt_evt,
  input wire logic osc_stop_evt,
  input wire logic lvd_evt,
  input wire logic step_evt,
  input wire logic [NPER-1:0] per_req,
  output logic [NPER-1:0] per_ack,
  // vector fetch
  output logic vf_rd,
  output logic [31:0] vf_addr,
  input wire logic [7:0] vf_rdata,
  // to core
  output logic busy,
  output logic jump,
  output logic [31:0] jump_pc,
  output logic [31:0] flag_out,
  output logic [31:0] saved_flag,
  output logic [31:0] saved_pc
);
  // ============================================================
  // state
  cis_state_t st_r;
  logic [31:0] flag_r, sflag_r, spc_r, fvec_r, vbase_r, fbase_r, vec_r;
  logic [31:0] jpc_r, sav_flag_r, sav_pc_r, rdata_r;
  logic [1:0] lca_r, lcb_r;
  logic [2:0] lvl_r [NPER];
  logic [NPEND-1:0] pend_r, pend_set, pend_clr;
  logic [7:0] int_num_r;
  logic nmi_d_r, nmi_fall, brk_r, rd_r;
  logic [2:0] cnt_r, got_r;
  // selection
  logic hit, take, sel_msk, sel_fast, sel_sw;
  logic [2:0] pk, best_lvl, ipl;
  logic [NPER-1:0] best_oh;
  logic [7:0] sel_num;
  logic [31:0] sel_addr;
  logic fast_on;

  assign ipl = flag_r[FB_IPL +: 3];
  // [RQ16] fast enable only with both selects set, dma off
  assign fast_on = lca_r[B_FSEL] & lcb_r[B_FSEL] & ~lca_r[B_DMA7] & ~lcb_r[B_DMA7];

  // ============================================================
  // pending sources
  // [RQ13] falling edge of the pin
  assign nmi_fall = nmi_d_r & ~nmi_pin_n;
  always_comb
  begin
    pend_set = '0;
    // [RQ4] undefined opcode
    pend_set[P_UND] = ex_undef;
    // [RQ5] overflow trap needs O set
    pend_set[P_OVF] = ex_ovf_trap & flag_r[FB_O];
    // [RQ7] break opcode
    pend_set[P_BRK] = ex_break;
    // [RQ8] separate debug break
    pend_set[P_DBG] = ex_dbg_break;
    // [RQ3] numbered trap
    pend_set[P_INT] = ex_int;
    // [RQ14] special sources
    pend_set[P_NMI] = nmi_fall;
    pend_set[P_SYS] = wdt_evt | osc_stop_evt | lvd_evt;
    pend_set[P_STEP] = step_evt;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      nmi_d_r <= 1'b1;
    else
      nmi_d_r <= nmi_pin_n;
  end

  // set beats clear so an event on the accept edge survives
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      pend_r <= '0;
    else
      pend_r <= pend_set | (pend_r & ~pend_clr);
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      int_num_r <= '0;
    else if (ex_int)
      int_num_r <= ex_int_num;
  end

  // ============================================================
  // arbitration
  always_comb
  begin
    hit = 1'b0;
    pk = '0;
    // [RQ2] fixed order, no enable gate
    for (int k = NPEND - 1; k >= 0; k--)
    begin
      if (pend_r[k])
      begin
        hit = 1'b1;
        pk = 3'(k);
      end
    end
    best_lvl = ipl;
    best_oh = '0;
    // [RQ1] highest level above ipl, ties to lower index
    for (int i = NPER - 1; i >= 0; i--)
    begin
      if (per_req[i] && lvl_r[i] >= best_lvl && lvl_r[i] > ipl)
      begin
        best_lvl = lvl_r[i];
        best_oh = NPER'(1) << i;
      end
    end
    sel_msk = 1'b0;
    sel_fast = 1'b0;
    sel_sw = 1'b0;
    sel_num = int_num_r;
    sel_addr = FIX_VEC[pk];
    if (hit)
    begin
      // [RQ10] low trap numbers select the interrupt stack
      // [RQ11] high trap numbers keep the stack
      sel_sw = (pk == 3'(P_INT)) && (int_num_r < INT_HI);
    end
    else if (flag_r[FB_I] && best_oh != '0)
    begin
      hit = 1'b1;
      sel_msk = 1'b1;
      sel_sw = 1'b1;
      // [RQ12] level 7 alone reaches the fast path
      // [RQ17] software keeps level 7 unique
      sel_fast = fast_on && best_lvl == LVL_FAST;
      for (int i = 0; i < NPER; i++)
      begin
        if (best_oh[i])
          // [RQ15] peripheral shares the trap slot
          sel_num = PER_NUM0 + 8'(i);
      end
    end
    // [RQ9] relocatable slot by number
    // [RQ22] 4 bytes per entry, 1024 byte table
    if (sel_msk || (hit && pk == 3'(P_INT)))
      sel_addr = vbase_r + 32'({sel_num, 2'b00});
  end

  // [RQ23] only at a boundary and while idle
  assign take = st_r == S_IDLE && insn_boundary && hit && !ex_fast_ret;
  assign per_ack = (take && sel_msk) ? best_oh : '0;

  // kept apart from arbitration so take never feeds back into its own process
  always_comb
  begin
    pend_clr = '0;
    if (take && !sel_msk)
      pend_clr[pk] = 1'b1;
  end

  // ============================================================
  // flag register
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      flag_r <= FLG_RST;
    else if (take)
    begin
      flag_r[FB_I] <= 1'b0;
      if (sel_sw)
        flag_r[FB_U] <= 1'b0;
      if (sel_msk)
        flag_r[FB_IPL +: 3] <= best_lvl;
    end
    // [RQ19] fast return restores shadow flags
    else if (ex_fast_ret && st_r == S_IDLE)
      flag_r <= sflag_r;
    // [RQ10] return restores saved U
    else if (ex_ret)
      flag_r <= ret_flag;
    else if (reg_wr && reg_addr == A_FLAG)
      flag_r <= reg_wdata;
    // [RQ6] arithmetic overflow result
    else if (alu_ovf_we)
      flag_r[FB_O] <= alu_ovf;
  end

  // [RQ18] shadow copies on fast accept
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sflag_r <= FLG_RST;
      spc_r <= VBASE_RST;
    end
    else if (take && sel_fast)
    begin
      sflag_r <= flag_r;
      spc_r <= cur_pc;
    end
  end

  // pre-accept context for the core to stack
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sav_flag_r <= FLG_RST;
      sav_pc_r <= VBASE_RST;
    end
    else if (take && !sel_fast)
    begin
      sav_flag_r <= flag_r;
      sav_pc_r <= cur_pc;
    end
  end

  // ============================================================
  // sequence and vector fetch
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= S_IDLE;
      fbase_r <= VBASE_RST;
      jpc_r <= VBASE_RST;
      vec_r <= VBASE_RST;
      cnt_r <= '0;
      got_r <= '0;
      brk_r <= 1'b0;
      rd_r <= 1'b0;
      vf_addr <= VBASE_RST;
    end
    else
    begin
      rd_r <= 1'b0;
      unique case (st_r)
        S_IDLE:
        begin
          if (take && sel_fast)
          begin
            // [RQ18] straight to the fast handler
            jpc_r <= fvec_r;
            st_r <= S_JUMP;
          end
          else if (take)
          begin
            // [RQ21] fixed slots at the top of memory
            fbase_r <= sel_addr;
            brk_r <= !sel_msk && pk == 3'(P_BRK);
            cnt_r <= '0;
            got_r <= '0;
            st_r <= S_FETCH;
          end
          else if (ex_fast_ret)
          begin
            // [RQ19] resume at shadow pc
            jpc_r <= spc_r;
            st_r <= S_JUMP;
          end
        end
        S_FETCH:
        begin
          // [RQ20] four byte reads, low byte first
          if (cnt_r != NBYTE)
          begin
            rd_r <= 1'b1;
            vf_addr <= fbase_r + 32'(cnt_r);
            cnt_r <= cnt_r + 3'h1;
          end
          if (rd_r)
          begin
            vec_r[got_r[1:0]*8 +: 8] <= vf_rdata;
            got_r <= got_r + 3'h1;
            if (got_r == NBYTE - 3'h1)
            begin
              // break slot with top byte FFh redirects to entry 0
              if (brk_r && vf_rdata == BYTE_FF)
              begin
                fbase_r <= vbase_r;
                brk_r <= 1'b0;
                cnt_r <= '0;
                got_r <= '0;
              end
              else
              begin
                jpc_r <= {vf_rdata, vec_r[23:0]};
                st_r <= S_JUMP;
              end
            end
          end
        end
        S_JUMP:
          st_r <= S_IDLE;
        default:
          st_r <= S_IDLE;
      endcase
    end
  end

  assign vf_rd = rd_r;
  assign busy = st_r != S_IDLE;
  assign jump = st_r == S_JUMP;
  assign jump_pc = jpc_r;
  assign flag_out = flag_r;
  assign saved_flag = sav_flag_r;
  assign saved_pc = sav_pc_r;

  // ============================================================
  // software registers
  genvar g;
  generate
    for (g = 0; g < NPER; g++)
    begin : g_lvl
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
          lvl_r[g] <= '0;
        // [RQ1] per source request level
        else if (reg_wr && reg_addr == A_LEVEL)
          lvl_r[g] <= reg_wdata[3*g +: 3];
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lca_r <= '0;
      lcb_r <= '0;
      fvec_r <= VBASE_RST;
      vbase_r <= VBASE_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == A_LCA)
        lca_r <= reg_wdata[1:0];
      if (reg_addr == A_LCB)
        lcb_r <= reg_wdata[1:0];
      if (reg_addr == A_FVEC)
        fvec_r <= reg_wdata;
      if (reg_addr == A_VBASE)
        vbase_r <= reg_wdata;
    end
  end

  // unmapped reads return zero
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_r <= '0;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        A_LEVEL:
        begin
          rdata_r <= '0;
          for (int i = 0; i < NPER; i++)
            rdata_r[3*i +: 3] <= lvl_r[i];
        end
        A_LCA: rdata_r <= 32'(lca_r);
        A_LCB: rdata_r <= 32'(lcb_r);
        A_FVEC: rdata_r <= fvec_r;
        A_VBASE: rdata_r <= vbase_r;
        A_STAT: rdata_r <= {21'(0), st_r, pend_r};
        A_FLAG: rdata_r <= flag_r;
        default: rdata_r <= '0;
      endcase
    end
    else
      rdata_r <= '0;
  end
  assign reg_rdata = rdata_r;

  // ============================================================
  // checks
  sequence s_four_reads;
    vf_rd [*4] ##1 !vf_rd;
  endsequence
  sequence s_fast_jump;
    jump && jump_pc == $past(fvec_r);
  endsequence

  property p_nmi_edge;
    @(posedge ref_clk) disable iff (!arst_n)
    nmi_fall |=> pend_r[P_NMI];
  endproperty
  a_nmi_edge: assert property (p_nmi_edge) // [RQ13]
    else $error("pin fall not latched");

  property p_mask;
    @(posedge ref_clk) disable iff (!arst_n)
    per_ack != '0 |-> flag_r[FB_I] && best_lvl > ipl && pend_r == '0;
  endproperty
  a_mask: assert property (p_mask) // [RQ1]
    else $error("masked peripheral accepted");

  property p_boundary;
    @(posedge ref_clk) disable iff (!arst_n)
    (st_r == S_IDLE && !insn_boundary) |=> st_r != S_FETCH;
  endproperty
  a_boundary: assert property (p_boundary) // [RQ23]
    else $error("accept off boundary");

  property p_ovf_clear;
    @(posedge ref_clk) disable iff (!arst_n)
    (ex_ovf_trap && !flag_r[FB_O] && !pend_r[P_OVF]) |=> !pend_r[P_OVF];
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) // [RQ5]
    else $error("overflow trap without O");

  property p_fast;
    @(posedge ref_clk) disable iff (!arst_n)
    (take && sel_fast) |=> (spc_r == $past(cur_pc) && sflag_r == $past(flag_r))
      and s_fast_jump;
  endproperty
  a_fast: assert property (p_fast) // [RQ18]
    else $error("fast accept wrong");

  property p_fetch;
    @(posedge ref_clk) disable iff (!arst_n)
    (take && !sel_fast) |=> ##1 s_four_reads;
  endproperty
  a_fetch: assert property (p_fetch) // [RQ20]
    else $error("vector fetch not four bytes");

  property p_stack_keep;
    @(posedge ref_clk) disable iff (!arst_n)
    (take && !sel_msk && pk == 3'(P_INT) && int_num_r >= INT_HI)
      |=> flag_r[FB_U] == $past(flag_r[FB_U]);
  endproperty
  a_stack_keep: assert property (p_stack_keep) // [RQ11]
    else $error("high trap changed stack");

  property p_stack_isp;
    @(posedge ref_clk) disable iff (!arst_n)
    (take && sel_sw) |=> !flag_r[FB_U] && saved_flag == $past(flag_r);
  endproperty
  a_stack_isp: assert property (p_stack_isp) // [RQ10]
    else $error("interrupt stack not selected");

  property p_fret;
    @(posedge ref_clk) disable iff (!arst_n)
    (ex_fast_ret && st_r == S_IDLE && !take) |=> flag_r == $past(sflag_r)
      && jump && jump_pc == $past(spc_r);
  endproperty
  a_fret: assert property (p_fret) // [RQ19]
    else $error("fast return wrong");
endmodule

// *** verification/cis_vec_mem.sv ***
// vector memory model on the far side of the fetch port
`timescale 1ns/1ps
module cis_vec_mem
(
  // clock
  input wire logic ref_clk,
  // fetch port
  input wire logic vf_rd,
  input wire logic [31:0] vf_addr,
  output logic [7:0] vf_rdata
);
  logic [7:0] last_r = 8'h00;
  logic [7:0] ans;
  // ============================================================
  // byte content
  // byte per address
  // content is low address byte plus 18h, so the break vector top byte is ffh
  assign ans = vf_addr[7:0] + 8'h18;
  always_ff @(posedge ref_clk)
  begin
    if (vf_rd)
      last_r <= ans;
  end
  // the sequencer takes the byte in its strobe cycle, so the answer is combinational;
  // outside that cycle the bus shows the inverse of the last byte, never a stale match
  assign vf_rdata = vf_rd ? ans : ~last_r;
endmodule

// *** verification/cis_sequencer_tb.sv ***
// self-checking bench for the cpu interrupt sequencer
`timescale 1ns/1ps
module cis_sequencer_tb;
  import cis_pkg::*;
  // ============================================================
  // signals
  localparam logic [31:0] VB = 32'h0000_1000;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0, reg_rd = 1'b0, insn_boundary = 1'b1;
  logic [31:0] cur_pc = 32'h1234_5678;
  logic [31:0] ret_flag = 32'h0000_0080;
  logic [6:0] ctl_v = 7'h00;
  logic [3:0] spec_v = 4'h0;
  logic [7:0] ex_int_num = 8'h00;
  logic [7:0] per_req = 8'h00;
  logic alu_ovf_we = 1'b0, alu_ovf = 1'b0, nmi_pin_n = 1'b1;
  logic [31:0] reg_rdata, vf_addr, jump_pc, flag_out, saved_flag, saved_pc;
  logic [7:0] per_ack, vf_rdata;
  logic vf_rd, busy, jump;
  logic [7:0] nums [4] = '{8'h80, 8'hFF, 8'h00, 8'h7F};
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  // ============================================================
  // design and far side
  cis_sequencer i_cis_sequencer (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .insn_boundary(insn_boundary), .cur_pc(cur_pc), .ex_undef(ctl_v[0]),
    .ex_ovf_trap(ctl_v[1]), .ex_break(ctl_v[2]), .ex_dbg_break(ctl_v[3]), .ex_int(ctl_v[4]),
    .ex_int_num(ex_int_num), .ex_fast_ret(ctl_v[5]), .ex_ret(ctl_v[6]), .ret_flag(ret_flag),
    .alu_ovf_we(alu_ovf_we), .alu_ovf(alu_ovf), .nmi_pin_n(nmi_pin_n), .wdt_evt(spec_v[0]),
    .osc_stop_evt(spec_v[1]), .lvd_evt(spec_v[2]), .step_evt(spec_v[3]), .per_req(per_req),
    .per_ack(per_ack), .vf_rd(vf_rd), .vf_addr(vf_addr), .vf_rdata(vf_rdata), .busy(busy),
    .jump(jump), .jump_pc(jump_pc), .flag_out(flag_out), .saved_flag(saved_flag),
    .saved_pc(saved_pc));
  cis_vec_mem i_cis_vec_mem (.ref_clk(ref_clk), .vf_rd(vf_rd), .vf_addr(vf_addr),
    .vf_rdata(vf_rdata));
  always #10 ref_clk = ~ref_clk;
  // ============================================================
  // helpers
  function automatic logic [31:0] vec(input logic [31:0] a);
    vec = {a[7:0] + 8'h1B, a[7:0] + 8'h1A, a[7:0] + 8'h19, a[7:0] + 8'h18};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic pulse(input logic [6:0] c, input logic [7:0] num);
    @(posedge ref_clk);
    ctl_v <= c;
    ex_int_num <= num;
    @(posedge ref_clk);
    ctl_v <= 7'h00;
  endtask
  task automatic wait_jump(input logic [31:0] exp);
    int n;
    n = 0;
    #1;
    while (jump !== 1'b1 && n < 40)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(32'(jump), 32'h0000_0001);
    @(posedge ref_clk);
    #1;
    // jump is a single-cycle pulse
    chk(32'(jump), 32'h0000_0000);
    chk(jump_pc, exp);
    chk(32'(busy), 32'h0000_0000);
  endtask
  task automatic no_jump(input int cnt);
    int hits;
    hits = 0;
    repeat (cnt)
    begin
      @(posedge ref_clk);
      #1;
      if (jump !== 1'b0)
        hits++;
    end
    chk(32'(hits), 32'h0000_0000);
  endtask
  task automatic wait_ack(input logic [7:0] exp);
    int n;
    n = 0;
    #1;
    while (per_ack === 8'h00 && n < 40)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk({24'h00_0000, per_ack}, {24'h00_0000, exp});
    @(posedge ref_clk);
    per_req <= per_req & ~exp;
  endtask
  // ============================================================
  // timeout: the whole run needs well under two thousand cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      conclude();
    end
  end
  // ============================================================
  // tests
  initial
  begin
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    reg_read(A_FLAG, FLG_RST);
    reg_read(A_VBASE, VBASE_RST);
    reg_read(8'h1C, 32'h0000_0000);
    reg_write(A_VBASE, VB);
    reg_read(A_VBASE, VB);
    $display("test registers done");
    @(posedge ref_clk);
    insn_boundary <= 1'b0;
    pulse(7'h01, 8'h00);
    no_jump(10);
    @(posedge ref_clk);
    insn_boundary <= 1'b1;
    wait_jump(vec(32'h0FFF_FFDC));
    pulse(7'h02, 8'h00);
    no_jump(20);
    @(posedge ref_clk);
    alu_ovf_we <= 1'b1;
    alu_ovf <= 1'b1;
    @(posedge ref_clk);
    alu_ovf_we <= 1'b0;
    #1;
    chk(flag_out, 32'h0000_0004);
    pulse(7'h02, 8'h00);
    wait_jump(vec(32'h0FFF_FFE0));
    pulse(7'h04, 8'h00);
    wait_jump(vec(VB));
    pulse(7'h08, 8'h00);
    wait_jump(vec(32'h0FFF_FFE8));
    $display("test software traps done");
    foreach (nums[i])
    begin
      reg_write(A_FLAG, 32'h0000_0080);
      pulse(7'h10, nums[i]);
      wait_jump(vec(VB + {22'h0, nums[i], 2'h0}));
      chk(flag_out & 32'h0000_0080, nums[i][7] ? 32'h0000_0080 : 32'h0000_0000);
      chk(saved_flag & 32'h0000_0080, 32'h0000_0080);
      chk(saved_pc, 32'h1234_5678);
    end
    pulse(7'h40, 8'h00);
    #1;
    chk(flag_out & 32'h0000_0080, 32'h0000_0080);
    $display("test numbered traps done");
    @(posedge ref_clk);
    nmi_pin_n <= 1'b0;
    wait_jump(vec(32'h0FFF_FFF8));
    no_jump(10);
    @(posedge ref_clk);
    nmi_pin_n <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge ref_clk);
      spec_v <= 4'h1 << k;
      @(posedge ref_clk);
      spec_v <= 4'h0;
      wait_jump(vec(k == 3 ? 32'h0FFF_FFEC : 32'h0FFF_FFF0));
    end
    $display("test special interrupts done");
    reg_write(A_LEVEL, 32'h0000_50C0);
    reg_write(A_FLAG, 32'h0000_0000);
    @(posedge ref_clk);
    per_req <= 8'h14;
    no_jump(20);
    reg_write(A_FLAG, 32'h0000_0040);
    wait_ack(8'h10);
    wait_jump(vec(VB + 32'h0000_0030));
    reg_write(A_FLAG, 32'h0000_0040);
    wait_ack(8'h04);
    wait_jump(vec(VB + 32'h0000_0028));
    $display("test peripheral requests done");
    reg_write(A_LCA, 32'h0000_0001);
    reg_write(A_LCB, 32'h0000_0003);
    reg_write(A_FVEC, 32'h0000_ABC0);
    reg_write(A_LEVEL, 32'h0000_0038);
    reg_read(A_LEVEL, 32'h0000_0038);
    reg_read(A_LCB, 32'h0000_0003);
    reg_write(A_FLAG, 32'h0000_0040);
    @(posedge ref_clk);
    per_req <= 8'h02;
    wait_ack(8'h02);
    wait_jump(vec(VB + 32'h0000_0024));
    reg_write(A_LCB, 32'h0000_0001);
    reg_write(A_FLAG, 32'h0000_0040);
    @(posedge ref_clk);
    per_req <= 8'h02;
    wait_ack(8'h02);
    #1;
    chk(32'(jump), 32'h0000_0001);
    chk(32'(busy), 32'h0000_0001);
    wait_jump(32'h0000_ABC0);
    pulse(7'h20, 8'h00);
    wait_jump(32'h1234_5678);
    chk(flag_out, 32'h0000_0040);
    $display("test fast path done");
    conclude();
  end
endmodule
